// ### src/wot_map.svh
/*
 Register offsets, field positions, reset values and divider counts
 of the wait one-shot timer. Definitions only; included by the timer.
*/
`ifndef WOT_MAP_SVH
`define WOT_MAP_SVH

// Byte offsets on the register port
`define WOT_ADDR_TCR        16'h0108
`define WOT_ADDR_OCR        16'h0109
`define WOT_ADDR_IOC        16'h010A
`define WOT_ADDR_SRC        16'h010B
`define WOT_ADDR_PRE        16'h010C
`define WOT_ADDR_SEC        16'h010D
`define WOT_ADDR_PRI        16'h010E

// timer_control_reg fields
`define WOT_TCR_START       0
`define WOT_TCR_FLAG        1
`define WOT_TCR_FSTOP       2

// one_shot_control_reg fields
`define WOT_OCR_OSSTART     0
`define WOT_OCR_OSSTOP      1
`define WOT_OCR_OSFLAG      2

// output_trigger_control fields
`define WOT_IOC_LEVEL       0
`define WOT_IOC_SWITCH      1
`define WOT_IOC_TRIG_EN     2
`define WOT_IOC_TRIG_POL    3
`define WOT_IOC_IMPL_W      4

// Reset values
`define WOT_RST_BYTE        8'h00
`define WOT_RST_IOC         4'h0
`define WOT_RST_RELOAD      8'hFF

// Divider terminal counts for the internal count sources
`define WOT_DIV_F2          1'h1
`define WOT_DIV_F8          3'h7

`endif

// ### src/wot_pkg.sv
/*
 Types of the wait one-shot timer.
 Assumes the map header supplies all numeric constants.
*/
package wot_pkg;

   typedef enum logic [1:0]
   {
      WOT_IDLE,
      WOT_WAIT,
      WOT_PULSE
   } wot_state_type;

   typedef enum logic [1:0]
   {
      WOT_SRC_F1,
      WOT_SRC_F2,
      WOT_SRC_F8,
      WOT_SRC_COMPANION
   } wot_src_type;

endpackage

// ### src/wot_timer.sv
/*
 8-bit timer with 8-bit prescaler in programmable wait one-shot mode,
 with byte register port, external trigger pin and pulse output.
 Assumes all inputs are synchronous to CLK except EXT_TRIGGER_IN, and
 that COMPANION_UNDERFLOW is a one-cycle pulse from a companion timer.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wot_map.svh"

// Notes on behaviour
// - Level bit picks pulse and idle polarity
// - Trigger enable gates external pin trigger
// - Polarity bit: 0 falling, 1 rising
// - Upper four control bits read zero
// - Halted after reset; load before start
// - Count pair read as separate bytes
// - Stop or one-shot stop reloads, halts
// - Start flag sets after 1-2 source cycles
// - Stop flag clears after 1-2 source cycles
// - Forced stop halts immediately
// - One-shot flag changes after 1-2 source cycles
// - Crossed one-shot start/stop: either result
// - Stopped writes load counter; running, reload only
// - Wait on primary, pulse on secondary
module wot_timer
   import wot_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        NRST,
   // Register port
   input  wire logic [15:0] ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   // Trigger and count source
   input  wire logic        EXT_TRIGGER_IN,
   input  wire logic        COMPANION_UNDERFLOW,
   // Timer outputs
   output logic             PULSE_OUT,
   output logic             COUNTING
);

   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction

   logic            start_reg;
   logic            start_next;
   logic            run_flag_reg;
   logic            run_flag_next;
   logic            run_stage_reg;
   logic            run_stage_next;
   logic            os_target_reg;
   logic            os_target_next;
   logic            os_flag_reg;
   logic            os_flag_next;
   logic            os_stage_reg;
   logic            os_stage_next;
   logic [3:0]      ioc_reg;
   wot_src_type     src_reg;
   logic [2:0]      div_reg;
   logic [7:0]      pre_rl_reg;
   logic [7:0]      sec_rl_reg;
   logic [7:0]      pri_rl_reg;
   logic [7:0]      pre_cnt_reg;
   logic [7:0]      pre_cnt_next;
   logic [7:0]      cnt_reg;
   logic [7:0]      cnt_next;
   wot_state_type   state_reg;
   wot_state_type   state_next;
   logic            trig_s1_reg;
   logic            trig_s2_reg;
   logic            trig_s3_reg;
   logic [7:0]      rdata_reg;
   logic            pulse_out_reg;

   // Register decode
   wire wr_tcr  = WR && hit(ADDR, `WOT_ADDR_TCR);
   wire wr_ocr  = WR && hit(ADDR, `WOT_ADDR_OCR);
   wire wr_ioc  = WR && hit(ADDR, `WOT_ADDR_IOC);
   wire wr_src  = WR && hit(ADDR, `WOT_ADDR_SRC);
   wire wr_pre  = WR && hit(ADDR, `WOT_ADDR_PRE);
   wire wr_sec  = WR && hit(ADDR, `WOT_ADDR_SEC);
   wire wr_pri  = WR && hit(ADDR, `WOT_ADDR_PRI);

   wire force_stop   = wr_tcr && WDATA[`WOT_TCR_FSTOP];
   wire level_sel    = ioc_reg[`WOT_IOC_LEVEL];
   wire trig_en      = ioc_reg[`WOT_IOC_TRIG_EN];
   wire trig_pol     = ioc_reg[`WOT_IOC_TRIG_POL];

   // Count source select
   wire src_tick = (src_reg == WOT_SRC_F1) ? 1'b1 :
                   (src_reg == WOT_SRC_F2) ? (div_reg[0] == `WOT_DIV_F2) :
                   (src_reg == WOT_SRC_F8) ? (div_reg == `WOT_DIV_F8) :
                   COMPANION_UNDERFLOW;

   // External trigger edge; s1 is read only by s2
   wire rise_edge = trig_s2_reg && !trig_s3_reg;
   wire fall_edge = !trig_s2_reg && trig_s3_reg;
   wire ext_edge  = (trig_pol ? rise_edge : fall_edge) && trig_en && run_flag_reg;

   wire os_start_req = (wr_ocr && WDATA[`WOT_OCR_OSSTART]) || ext_edge;
   wire os_stop_req  = wr_ocr && WDATA[`WOT_OCR_OSSTOP];

   // Counting chain
   wire count_en = run_flag_reg && os_flag_reg && (state_reg != WOT_IDLE) && src_tick;
   wire pre_uf   = count_en && (pre_cnt_reg == 8'h00);
   wire main_uf  = pre_uf && (cnt_reg == 8'h00);
   wire sec_done = main_uf && (state_reg == WOT_PULSE);
   wire run_fall = run_flag_reg && !run_flag_next;
   wire os_fall  = os_flag_reg && !os_flag_next && !sec_done;
   wire halt_evt = run_fall || os_fall;

   // Readback; reserved and write-only bits read zero
   wire [7:0] rd_val =
      hit(ADDR, `WOT_ADDR_TCR) ? {5'h00, 1'b0, run_flag_reg, start_reg} :
      hit(ADDR, `WOT_ADDR_OCR) ? {5'h00, os_flag_reg, 2'h0} :
      hit(ADDR, `WOT_ADDR_IOC) ? {4'h0, ioc_reg} :
      hit(ADDR, `WOT_ADDR_SRC) ? {6'h00, src_reg} :
      hit(ADDR, `WOT_ADDR_PRE) ? pre_cnt_reg :
      hit(ADDR, `WOT_ADDR_SEC) ? sec_rl_reg :
      hit(ADDR, `WOT_ADDR_PRI) ? cnt_reg :
      `WOT_RST_BYTE;

   // Start bit; forced stop clears it too
   assign start_next = force_stop ? 1'b0 :
                       wr_tcr ? WDATA[`WOT_TCR_START] : start_reg;

   // Run flag follows start bit after two source ticks, forced stop at once
   always_comb
   begin
      run_flag_next  = run_flag_reg;
      run_stage_next = run_stage_reg;
      if (force_stop)
      begin
         run_flag_next  = 1'b0;
         run_stage_next = 1'b0;
      end
      else if (start_reg == run_flag_reg)
         run_stage_next = 1'b0;
      else if (src_tick)
      begin
         if (run_stage_reg)
         begin
            run_flag_next  = start_reg;
            run_stage_next = 1'b0;
         end
         else
            run_stage_next = 1'b1;
      end
   end

   // One-shot flag; a late request overrides a pending one
   always_comb
   begin
      os_target_next = os_target_reg;
      os_flag_next   = os_flag_reg;
      os_stage_next  = os_stage_reg;
      if (os_stop_req)
         os_target_next = 1'b0;
      else if (os_start_req)
         os_target_next = 1'b1;
      if (force_stop || run_fall || sec_done)
      begin
         os_target_next = 1'b0;
         os_flag_next   = 1'b0;
         os_stage_next  = 1'b0;
      end
      else if (os_target_reg == os_flag_reg)
         os_stage_next = 1'b0;
      else if (src_tick)
      begin
         if (os_stage_reg)
         begin
            os_flag_next  = os_target_reg;
            os_stage_next = 1'b0;
         end
         else
            os_stage_next = 1'b1;
      end
   end

   // Prescaler, counter and phase
   always_comb
   begin
      pre_cnt_next = pre_cnt_reg;
      cnt_next     = cnt_reg;
      state_next   = state_reg;
      if (halt_evt)
      begin
         pre_cnt_next = pre_rl_reg;
         cnt_next     = pri_rl_reg;
         state_next   = WOT_IDLE;
      end
      else if (count_en)
      begin
         pre_cnt_next = pre_uf ? pre_rl_reg : pre_cnt_reg - 8'h01;
         if (main_uf)
         begin
            case (state_reg)
               WOT_WAIT:
               begin
                  cnt_next   = sec_rl_reg;
                  state_next = WOT_PULSE;
               end
               WOT_PULSE:
               begin
                  cnt_next   = pri_rl_reg;
                  state_next = WOT_IDLE;
               end
               default:
                  state_next = WOT_IDLE;
            endcase
         end
         else if (pre_uf)
            cnt_next = cnt_reg - 8'h01;
      end
      else if (!os_flag_reg && os_flag_next && run_flag_reg)
         state_next = WOT_WAIT;
      // Stopped writes reach the counters; running writes wait for reload
      if (!run_flag_reg && wr_pre)
         pre_cnt_next = WDATA;
      if (!run_flag_reg && wr_pri)
         cnt_next = WDATA;
   end

   // Control state; halted after reset
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         start_reg     <= 1'b0;
         run_flag_reg  <= 1'b0;
         run_stage_reg <= 1'b0;
         os_target_reg <= 1'b0;
         os_flag_reg   <= 1'b0;
         os_stage_reg  <= 1'b0;
         state_reg     <= WOT_IDLE;
      end
      else
      begin
         start_reg     <= start_next;
         run_flag_reg  <= run_flag_next;
         run_stage_reg <= run_stage_next;
         os_target_reg <= os_target_next;
         os_flag_reg   <= os_flag_next;
         os_stage_reg  <= os_stage_next;
         state_reg     <= state_next;
      end
   end

   // Configuration and reload registers; output switch bit stored only
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ioc_reg    <= `WOT_RST_IOC;
         src_reg    <= WOT_SRC_F1;
         pre_rl_reg <= `WOT_RST_RELOAD;
         sec_rl_reg <= `WOT_RST_RELOAD;
         pri_rl_reg <= `WOT_RST_RELOAD;
      end
      else
      begin
         if (wr_ioc)
            ioc_reg <= WDATA[`WOT_IOC_IMPL_W-1:0];
         if (wr_src)
            src_reg <= wot_src_type'(WDATA[1:0]);
         if (wr_pre)
            pre_rl_reg <= WDATA;
         if (wr_sec)
            sec_rl_reg <= WDATA;
         if (wr_pri)
            pri_rl_reg <= WDATA;
      end
   end

   // Counters, divider, trigger synchroniser, outputs
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pre_cnt_reg   <= `WOT_RST_RELOAD;
         cnt_reg       <= `WOT_RST_RELOAD;
         div_reg       <= 3'h0;
         trig_s1_reg   <= 1'b0;
         trig_s2_reg   <= 1'b0;
         trig_s3_reg   <= 1'b0;
         rdata_reg     <= `WOT_RST_BYTE;
         pulse_out_reg <= 1'b0;
      end
      else
      begin
         pre_cnt_reg   <= pre_cnt_next;
         cnt_reg       <= cnt_next;
         div_reg       <= div_reg + 3'h1;
         trig_s1_reg   <= EXT_TRIGGER_IN;
         trig_s2_reg   <= trig_s1_reg;
         trig_s3_reg   <= trig_s2_reg;
         rdata_reg     <= RD ? rd_val : `WOT_RST_BYTE;
         pulse_out_reg <= (state_reg == WOT_PULSE) ^ level_sel;
      end
   end

   assign RDATA     = rdata_reg;
   assign PULSE_OUT = pulse_out_reg;
   assign COUNTING  = run_flag_reg;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   chk_out_level: assert property (
      (state_reg != WOT_PULSE) |=> (PULSE_OUT == $past(level_sel)))
      else $error("Idle output level wrong");
   chk_pulse_level: assert property (
      (state_reg == WOT_PULSE) |=> (PULSE_OUT == !$past(level_sel)))
      else $error("Pulse output level wrong");
   chk_rsvd_zero: assert property (
      (RD && hit(ADDR, `WOT_ADDR_IOC)) |=> (RDATA[7:4] == 4'h0))
      else $error("Reserved control bits not zero");
   chk_trig_gate: assert property (
      (!trig_en && !wr_ocr) |-> !os_start_req)
      else $error("Disabled trigger started one-shot");
   chk_trig_rise: assert property (
      (trig_en && trig_pol && run_flag_reg && rise_edge) |-> os_start_req)
      else $error("Rising edge trigger missed");
   chk_trig_once: assert property (
      ext_edge |=> !ext_edge)
      else $error("Trigger edge gave two requests");
   chk_read_byte: assert property (
      (RD && hit(ADDR, `WOT_ADDR_PRE)) |=> (RDATA == $past(pre_cnt_reg)))
      else $error("Prescaler readback wrong");
   chk_start_sync: assert property (
      ($changed(run_flag_reg) && !$past(force_stop)) |-> ($past(src_tick) && $past(run_stage_reg)))
      else $error("Run flag changed without two ticks");
   chk_stop_reload: assert property (
      halt_evt |=> (cnt_reg == $past(pri_rl_reg)) && (state_reg == WOT_IDLE))
      else $error("Stop did not reload counter");
   chk_force_stop: assert property (
      force_stop |=> (!run_flag_reg && !start_reg))
      else $error("Forced stop not immediate");
   chk_os_sync: assert property (
      ($rose(os_flag_reg)) |-> ($past(src_tick) && $past(os_stage_reg)))
      else $error("One-shot flag set without two ticks");
   chk_write_stopped: assert property (
      (wr_pri && !run_flag_reg) |=> (cnt_reg == $past(WDATA)))
      else $error("Stopped write missed counter");
   chk_sec_done: assert property (
      sec_done |=> (!os_flag_reg && (cnt_reg == $past(pri_rl_reg)) && (state_reg == WOT_IDLE)))
      else $error("Pulse end did not reload primary");

   cov_full_shot: cover property (state_reg == WOT_WAIT ##[1:1000] state_reg == WOT_PULSE
                                  ##[1:1000] state_reg == WOT_IDLE);
   cov_ext_start: cover property (ext_edge ##[1:8] os_flag_reg);
   cov_force: cover property (force_stop && run_flag_reg);
   cov_os_stop: cover property (os_stop_req && state_reg == WOT_WAIT);

endmodule
`default_nettype wire

// ### sim/test_wait_one_shot_timer_control.sv
/*
 Self-checking bench of the wait one-shot timer: register port,
 start and stop sync, pulse timing per count source, external trigger.
 Assumes wot_timer and its map header are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wot_map.svh"
module test_wait_one_shot_timer_control;
   logic        clk;
   logic        nrst;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        ext;
   logic        comp;
   logic        pulse;
   logic        counting;
   logic [1:0]  n4;
   logic [7:0]  d;
   bit          comp_on;
   int          num_errors;
   int          n_tests;
   int          n;
   int          per_tab [4] = '{1, 2, 8, 4};

   wot_timer wot_timer_inst
   (
      .CLK                 (clk),
      .NRST                (nrst),
      .ADDR                (addr),
      .WDATA               (wdata),
      .WR                  (wr),
      .RD                  (rd),
      .RDATA               (rdata),
      .EXT_TRIGGER_IN      (ext),
      .COMPANION_UNDERFLOW (comp),
      .PULSE_OUT           (pulse),
      .COUNTING            (counting)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Companion underflow every 4th cycle, only when selected
   always @(posedge clk)
   begin
      n4 <= n4 + 2'h1;
      comp <= comp_on && (n4 == 2'h3);
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   // Bounded waits; a hang shows up as a wrong count
   task automatic wait_run(input logic v, input int lim, output int c);
      c = 0;
      while (counting !== v && c < lim)
      begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask

   task automatic pulse_len(input logic act, input int lim, output int len);
      int c;
      c = 0;
      len = 0;
      while (pulse !== act && c < lim)
      begin
         @(posedge clk);
         #1;
         c++;
      end
      while (pulse === act && len < lim)
      begin
         @(posedge clk);
         #1;
         len++;
      end
   endtask

   task automatic count_pulses(input int span, output int k);
      logic prev;
      prev = pulse;
      k = 0;
      repeat (span)
      begin
         @(posedge clk);
         #1;
         if (pulse === 1'b1 && prev !== 1'b1)
            k++;
         prev = pulse;
      end
   endtask

   task automatic run(input logic on, input int p);
      int c;
      wr_reg(`WOT_ADDR_TCR, 8'(on));
      check("run_hold", 8'(counting), 8'(!on));
      wait_run(on, 4 * p + 4, c);
      check("run_sync", 8'(c <= 2 * p + 2), 8'h01);
   endtask

   // Wait 6 ticks, pulse 8 ticks with pre 1, pri 2, sec 3
   task automatic shot(input logic [1:0] src, input int p, input logic act);
      int c;
      wr_reg(`WOT_ADDR_SRC, {6'h00, src});
      run(1'b1, p);
      wr_reg(`WOT_ADDR_OCR, 8'h01);
      pulse_len(act, 400, c);
      check("pulse_len", 8'(c), 8'(8 * p));
      rd_reg(`WOT_ADDR_OCR, d);
      check("os_flag_end", d & 8'h04, 8'h00);
      rd_reg(`WOT_ADDR_PRI, d);
      check("pri_reload", d, 8'h02);
      run(1'b0, p);
   endtask

   task automatic edge_test(input logic lvl, input int exp);
      @(posedge clk);
      ext <= lvl;
      count_pulses(100, n);
      check("trigger", 8'(n), 8'(exp));
   endtask

   initial
   begin
      #160000;
      num_errors++;
      results();
   end

   initial
   begin
      nrst = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext = 1'b1;
      comp = 1'b0;
      n4 = 2'h0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check("pulse_rst", 8'(pulse), 8'h00);
      check("run_rst", 8'(counting), 8'h00);
      rd_reg(`WOT_ADDR_IOC, d);
      check("ioc_rst", d, 8'h00);
      // Switch bit and upper bits kept zero by software
      wr_reg(`WOT_ADDR_IOC, 8'h0D);
      rd_reg(`WOT_ADDR_IOC, d);
      check("ioc_upper", d, 8'h0D);
      rd_reg(16'h0100, d);
      check("unmapped", d, 8'h00);
      wr_reg(`WOT_ADDR_IOC, 8'h00);
      wr_reg(`WOT_ADDR_PRE, 8'h01);
      wr_reg(`WOT_ADDR_SEC, 8'h03);
      wr_reg(`WOT_ADDR_PRI, 8'h02);
      rd_reg(`WOT_ADDR_PRI, d);
      check("pri_stopped", d, 8'h02);
      rd_reg(`WOT_ADDR_PRE, d);
      check("pre_stopped", d, 8'h01);
      $display("test registers done");
      for (int s = 0; s < 4; s++)
      begin
         comp_on = (s == 3);
         shot(2'(s), per_tab[s], 1'b1);
      end
      comp_on = 1'b0;
      $display("test count sources done");
      // Inverted level: idle high, pulse low
      wr_reg(`WOT_ADDR_IOC, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      check("idle_high", 8'(pulse), 8'h01);
      shot(2'h0, 1, 1'b0);
      wr_reg(`WOT_ADDR_IOC, 8'h00);
      $display("test output level done");
      // Running writes reach reload only; single writes keep the spacing
      run(1'b1, 1);
      wr_reg(`WOT_ADDR_PRI, 8'h05);
      wr_reg(`WOT_ADDR_PRE, 8'h03);
      rd_reg(`WOT_ADDR_PRI, d);
      check("pri_running", d, 8'h02);
      rd_reg(`WOT_ADDR_PRE, d);
      check("pre_running", d, 8'h01);
      run(1'b0, 1);
      rd_reg(`WOT_ADDR_PRI, d);
      check("pri_stop", d, 8'h05);
      rd_reg(`WOT_ADDR_PRE, d);
      check("pre_stop", d, 8'h03);
      wr_reg(`WOT_ADDR_PRE, 8'h01);
      // One-shot stop in mid-wait ends without a pulse
      run(1'b1, 1);
      wr_reg(`WOT_ADDR_OCR, 8'h01);
      repeat (4) @(posedge clk);
      rd_reg(`WOT_ADDR_OCR, d);
      check("os_flag_set", d & 8'h04, 8'h04);
      wr_reg(`WOT_ADDR_OCR, 8'h02);
      count_pulses(60, n);
      check("os_stop_pulses", 8'(n), 8'h00);
      rd_reg(`WOT_ADDR_OCR, d);
      check("os_flag_clr", d & 8'h04, 8'h00);
      // Forced stop skips the sync delay
      wr_reg(`WOT_ADDR_OCR, 8'h01);
      repeat (4) @(posedge clk);
      wr_reg(`WOT_ADDR_TCR, 8'h05);
      @(posedge clk);
      #1;
      check("forced_stop", 8'(counting), 8'h00);
      count_pulses(60, n);
      check("forced_pulses", 8'(n), 8'h00);
      rd_reg(`WOT_ADDR_PRI, d);
      check("forced_reload", d, 8'h05);
      wr_reg(`WOT_ADDR_TCR, 8'h00);
      wait_run(1'b0, 10, n);
      wr_reg(`WOT_ADDR_PRI, 8'h02);
      $display("test stops done");
      // External trigger: disabled, falling, rising
      run(1'b1, 1);
      edge_test(1'b0, 0);
      edge_test(1'b1, 0);
      wr_reg(`WOT_ADDR_IOC, 8'h04);
      edge_test(1'b0, 1);
      edge_test(1'b1, 0);
      wr_reg(`WOT_ADDR_IOC, 8'h0C);
      edge_test(1'b0, 0);
      edge_test(1'b1, 1);
      run(1'b0, 1);
      $display("test external trigger done");
      results();
   end
endmodule
`default_nettype wire
